/* File: hdl/loch_handler.sv */
`timescale 1ns/1ps
`default_nettype none
`include "loch_params.svh"
module loch_handler (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic [31:0] dyn_gateway_i,
  input wire logic [31:0] dyn_nserver_i,
  output loch_pkg::loch_cfg_t net_cfg_o,
  output logic [31:0] gateway_o,
  output logic [31:0] nserver_o,
  output logic output_en_o,
  output logic ready_o
);
  import loch_pkg::*;

  loch_cfg_t cfg_reg;
  logic [31:0] gateway_reg;
  logic [31:0] nserver_reg;
  logic out_en_reg;
  logic locked_reg;
  loch_boot_t boot_reg;
  logic aw_held_reg;
  logic w_held_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic nv_wr_reg;
  logic [0:0] nv_wr_idx_reg;
  logic [31:0] nv_wr_data_reg;
  logic [0:0] nv_rd_idx;
  logic [31:0] nv_rd_data;
  logic [31:0] nv_cfg_reg;
  logic wr_fire;
  logic booted;
  logic [31:0] gate_merge;
  logic [31:0] ns_merge;

  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
      input logic [31:0] new_v, input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic wr_mapped(input logic [7:0] addr);
    logic hit;
    hit = 1'b0;
    unique case (addr)
      `LOCH_OFS_CTRL, `LOCH_OFS_GATEWAY, `LOCH_OFS_NSERVER, `LOCH_OFS_CMD: begin
        hit = 1'b1;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    return hit;
  endfunction

  // address in use: learned while automatic, else static
  function automatic logic [31:0] gw_in_use(input loch_cfg_t cfg, input logic [31:0] learned,
      input logic [31:0] fixed);
    return cfg.auto_addr ? learned : fixed;
  endfunction

  function automatic logic [31:0] ns_in_use(input loch_cfg_t cfg, input logic [31:0] learned,
      input logic [31:0] fixed);
    return (cfg.auto_addr || cfg.ns_auto) ? learned : fixed;
  endfunction

  function automatic logic [31:0] ctrl_word(input loch_cfg_t cfg);
    logic [31:0] w;
    w = 32'h00000000;
    w[`LOCH_CTRL_AUTO_ADDR] = cfg.auto_addr;
    w[`LOCH_CTRL_NS_AUTO] = cfg.ns_auto;
    w[`LOCH_CTRL_POLICY_LAST] = cfg.policy_last;
    return w;
  endfunction

  function automatic logic [31:0] status_word(input logic policy, input logic nv_pulse,
      input logic locked, input logic out_en);
    logic [31:0] w;
    w = 32'h00000000;
    w[`LOCH_STAT_OUT_EN] = out_en;
    w[`LOCH_STAT_LOCKED] = locked;
    w[`LOCH_STAT_NV_BUSY] = nv_pulse;
    w[`LOCH_STAT_POLICY] = policy;
    return w;
  endfunction

  // old index picks the data bound for the word written next
  function automatic logic [31:0] nv_word(input logic [0:0] idx, input logic out_en,
      input logic policy);
    logic [31:0] w;
    w = 32'h00000000;
    if (idx == `LOCH_NV_IDX_CFG) begin
      w[0] = out_en;
    end else begin
      w[`LOCH_CTRL_POLICY_LAST] = policy;
    end
    return w;
  endfunction

  assign booted = (boot_reg == LOCH_BOOT_DONE);
  assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid_o && booted;
  assign gate_merge = merge_bytes(gateway_reg, w_data_reg, w_strb_reg);
  assign ns_merge = merge_bytes(nserver_reg, w_data_reg, w_strb_reg);
  assign nv_rd_idx = (boot_reg == LOCH_BOOT_READ_CFG) ? `LOCH_NV_IDX_CFG : `LOCH_NV_IDX_OUT;

  loch_nv_mem u_nv (
    .clk_i(clk_i),
    .wr_en_i(nv_wr_reg),
    .wr_idx_i(nv_wr_idx_reg),
    .wr_data_i(nv_wr_data_reg),
    .rd_idx_i(nv_rd_idx),
    .rd_data_o(nv_rd_data)
  );

  // boot: read back retained policy and output state
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      boot_reg <= LOCH_BOOT_READ_CFG;
      nv_cfg_reg <= 32'h00000000;
      ready_o <= 1'b0;
    end else begin
      unique case (boot_reg)
        LOCH_BOOT_READ_CFG: begin
          boot_reg <= LOCH_BOOT_READ_OUT;
        end
        LOCH_BOOT_READ_OUT: begin
          nv_cfg_reg <= nv_rd_data;
          boot_reg <= LOCH_BOOT_APPLY;
        end
        LOCH_BOOT_APPLY: begin
          boot_reg <= LOCH_BOOT_DONE;
          ready_o <= 1'b1;
        end
        LOCH_BOOT_DONE: begin
          boot_reg <= LOCH_BOOT_DONE;
        end
      endcase
    end
  end

  // write address and data channels, either order
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o <= 1'b0;
    end else begin
      s_axi_awready_o <= !aw_held_reg && !(s_axi_awvalid_i && s_axi_awready_o);
      s_axi_wready_o <= !w_held_reg && !(s_axi_wvalid_i && s_axi_wready_o);
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr_i;
      end else if (wr_fire) begin
        aw_held_reg <= 1'b0;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata_i;
        w_strb_reg <= s_axi_wstrb_i;
      end else if (wr_fire) begin
        w_held_reg <= 1'b0;
      end
    end
  end

  // write response
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= `LOCH_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid_o <= 1'b1;
      s_axi_bresp_o <= wr_mapped(aw_addr_reg) ? `LOCH_RESP_OKAY : `LOCH_RESP_SLVERR;
    end else if (s_axi_bready_i) begin
      s_axi_bvalid_o <= 1'b0;
    end
  end

  // network configuration and power-up policy
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cfg_reg <= '0;
      gateway_reg <= `LOCH_GATEWAY_RST;
      nserver_reg <= `LOCH_NSERVER_RST;
    end else if (boot_reg == LOCH_BOOT_APPLY) begin
      cfg_reg.policy_last <= nv_cfg_reg[`LOCH_CTRL_POLICY_LAST];
    end else if (wr_fire && w_strb_reg[0] && aw_addr_reg == `LOCH_OFS_CTRL) begin
      cfg_reg.auto_addr <= w_data_reg[`LOCH_CTRL_AUTO_ADDR];
      cfg_reg.ns_auto <= w_data_reg[`LOCH_CTRL_NS_AUTO];
      cfg_reg.policy_last <= w_data_reg[`LOCH_CTRL_POLICY_LAST];
    end else if (wr_fire && aw_addr_reg == `LOCH_OFS_GATEWAY && !cfg_reg.auto_addr) begin
      gateway_reg <= gate_merge;
    end else if (wr_fire && aw_addr_reg == `LOCH_OFS_NSERVER && !cfg_reg.auto_addr) begin
      nserver_reg <= ns_merge;
    end
  end

  // output enable with restore lock
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      out_en_reg <= 1'b0;
      locked_reg <= 1'b0;
    end else if (boot_reg == LOCH_BOOT_APPLY) begin
      if (nv_cfg_reg[`LOCH_CTRL_POLICY_LAST] && nv_rd_data[0]) begin
        out_en_reg <= 1'b1;
        locked_reg <= 1'b1;
      end else begin
        out_en_reg <= 1'b0;
        locked_reg <= 1'b0;
      end
    end else if (wr_fire && w_strb_reg[0] && aw_addr_reg == `LOCH_OFS_CMD) begin
      if (w_data_reg[`LOCH_CMD_FULL_RESET]) begin
        out_en_reg <= 1'b0;
        locked_reg <= 1'b0;
      end else if (w_data_reg[`LOCH_CMD_OUT_ON]) begin
        out_en_reg <= 1'b1;
      end else if (w_data_reg[`LOCH_CMD_OUT_OFF] && !locked_reg) begin
        out_en_reg <= 1'b0;
      end
    end
  end

  // retention write-back of policy and output state
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      nv_wr_reg <= 1'b0;
      nv_wr_idx_reg <= `LOCH_NV_IDX_CFG;
      nv_wr_data_reg <= 32'h00000000;
    end else if (booted && !nv_wr_reg) begin
      nv_wr_reg <= 1'b1;
      nv_wr_idx_reg <= ~nv_wr_idx_reg;
      nv_wr_data_reg <= nv_word(nv_wr_idx_reg, out_en_reg, cfg_reg.policy_last);
    end else begin
      nv_wr_reg <= 1'b0;
    end
  end

  // read channel
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h00000000;
      s_axi_rresp_o <= `LOCH_RESP_OKAY;
    end else begin
      s_axi_arready_o <= !s_axi_rvalid_o && !(s_axi_arvalid_i && s_axi_arready_o);
      if (s_axi_arvalid_i && s_axi_arready_o) begin
        s_axi_rvalid_o <= 1'b1;
        s_axi_rresp_o <= `LOCH_RESP_OKAY;
        unique case (s_axi_araddr_i)
          `LOCH_OFS_CTRL: begin
            s_axi_rdata_o <= ctrl_word(cfg_reg);
          end
          `LOCH_OFS_GATEWAY: begin
            s_axi_rdata_o <= gw_in_use(cfg_reg, dyn_gateway_i, gateway_reg);
          end
          `LOCH_OFS_NSERVER: begin
            s_axi_rdata_o <= ns_in_use(cfg_reg, dyn_nserver_i, nserver_reg);
          end
          `LOCH_OFS_STATUS: begin
            s_axi_rdata_o <= status_word(cfg_reg.policy_last, nv_wr_reg, locked_reg,
                                         out_en_reg);
          end
          `LOCH_OFS_CMD: begin
            s_axi_rdata_o <= 32'h00000000;
          end
          default: begin
            s_axi_rdata_o <= 32'h00000000;
            s_axi_rresp_o <= `LOCH_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rready_i) begin
        s_axi_rvalid_o <= 1'b0;
      end
    end
  end

  // registered outputs
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      net_cfg_o <= '0;
      gateway_o <= `LOCH_GATEWAY_RST;
      nserver_o <= `LOCH_NSERVER_RST;
      output_en_o <= 1'b0;
    end else begin
      net_cfg_o <= cfg_reg;
      gateway_o <= gw_in_use(cfg_reg, dyn_gateway_i, gateway_reg);
      nserver_o <= ns_in_use(cfg_reg, dyn_nserver_i, nserver_reg);
      output_en_o <= out_en_reg;
    end
  end
endmodule // loch_handler
`default_nettype wire

/* File: hdl/loch_nv_mem.sv */
`timescale 1ns/1ps
`default_nettype none
`include "loch_params.svh"
module loch_nv_mem (
  input wire logic clk_i,
  input wire logic wr_en_i,
  input wire logic [0:0] wr_idx_i,
  input wire logic [31:0] wr_data_i,
  input wire logic [0:0] rd_idx_i,
  output logic [31:0] rd_data_o
);
  // retention cells, not cleared by reset
  logic [31:0] cell_reg [`LOCH_NV_WORDS];

  always_ff @(posedge clk_i) begin
    if (wr_en_i) begin
      cell_reg[wr_idx_i] <= wr_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    rd_data_o <= cell_reg[rd_idx_i];
  end
endmodule // loch_nv_mem
`default_nettype wire

/* File: hdl/loch_params.svh */
`ifndef LOCH_PARAMS_SVH
`define LOCH_PARAMS_SVH
`define LOCH_OFS_CTRL 8'h00
`define LOCH_OFS_GATEWAY 8'h04
`define LOCH_OFS_NSERVER 8'h08
`define LOCH_OFS_STATUS 8'h0C
`define LOCH_OFS_CMD 8'h10
`define LOCH_OFS_NV_DATA 8'h14
`define LOCH_CTRL_AUTO_ADDR 0
`define LOCH_CTRL_NS_AUTO 1
`define LOCH_CTRL_POLICY_LAST 2
`define LOCH_CMD_OUT_ON 0
`define LOCH_CMD_OUT_OFF 1
`define LOCH_CMD_FULL_RESET 2
`define LOCH_STAT_OUT_EN 0
`define LOCH_STAT_LOCKED 1
`define LOCH_STAT_NV_BUSY 2
`define LOCH_STAT_POLICY 3
`define LOCH_RESP_OKAY 2'h0
`define LOCH_RESP_SLVERR 2'h2
`define LOCH_NV_WORDS 2
`define LOCH_NV_IDX_CFG 1'h0
`define LOCH_NV_IDX_OUT 1'h1
`define LOCH_GATEWAY_RST 32'h00000000
`define LOCH_NSERVER_RST 32'h00000000
`endif

/* File: hdl/loch_pkg.sv */
package loch_pkg;
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] data;
  } loch_req_t;
  typedef struct packed {
    logic auto_addr;
    logic ns_auto;
    logic policy_last;
  } loch_cfg_t;
  typedef enum logic [1:0] {
    LOCH_BOOT_READ_CFG,
    LOCH_BOOT_READ_OUT,
    LOCH_BOOT_APPLY,
    LOCH_BOOT_DONE
  } loch_boot_t;
endpackage

/* File: test/loch_chk.sv */
`timescale 1ns/1ps
`default_nettype none
`include "loch_params.svh"
module loch_chk (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [31:0] dyn_gateway_i,
  input wire logic [31:0] dyn_nserver_i,
  input wire loch_pkg::loch_cfg_t net_cfg_o,
  input wire logic [31:0] gateway_o,
  input wire logic [31:0] nserver_o,
  input wire logic output_en_o,
  input wire logic ready_o
);
  import loch_pkg::*;
  logic rdy_reg, lock_reg, wr_done, cmd;
  logic [2:0] op;
  assign wr_done = s_axi_bvalid_o && s_axi_bready_i;
  assign cmd = wr_done && s_axi_awaddr_i == `LOCH_OFS_CMD;
  assign op = s_axi_wdata_i[2:0];
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) rdy_reg <= 1'b0;
    else rdy_reg <= ready_o;
  end
  // restored-on under last policy locks out the off command
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) lock_reg <= 1'b0;
    else if ($rose(rdy_reg)) lock_reg <= output_en_o && net_cfg_o.policy_last;
    else if (cmd && op[2]) lock_reg <= 1'b0;
  end
  default clocking dc @(posedge clk_i);
  endclocking
  default disable iff (!arst_n_i);
  sequence on_held_s;
    output_en_o ##1 output_en_o ##1 output_en_o;
  endsequence
  ctrl_write_a: assert property (wr_done && s_axi_awaddr_i == `LOCH_OFS_CTRL
    |-> ##[0:2] net_cfg_o == {op[0], op[1], op[2]}) else $error("ctrl not applied");
  out_on_a: assert property (cmd && op == 3'h1 |-> ##[0:2] output_en_o)
    else $error("output not on");
  out_off_a: assert property (cmd && op == 3'h2 && !lock_reg |-> ##[0:2] !output_en_o)
    else $error("output not off");
  full_rst_a: assert property (cmd && op[2] |-> ##[0:2] !output_en_o)
    else $error("full reset kept output");
  lock_hold_a: assert property (cmd && op == 3'h2 && lock_reg |-> on_held_s)
    else $error("locked output went off");
  boot_off_a: assert property ($rose(rdy_reg) && !net_cfg_o.policy_last |-> !output_en_o)
    else $error("output on after boot");
  gw_auto_a: assert property ((net_cfg_o.auto_addr && $stable(dyn_gateway_i))[*3]
    |-> gateway_o == dyn_gateway_i) else $error("gateway not learned");
  ns_auto_a: assert property (((net_cfg_o.auto_addr || net_cfg_o.ns_auto)
    && $stable(dyn_nserver_i))[*3] |-> nserver_o == dyn_nserver_i) else $error("nserver wrong");
endmodule // loch_chk
bind loch_handler loch_chk i_loch_chk (.*);
`default_nettype wire

/* File: test/loch_dhcp_model.sv */
`timescale 1ns/1ps
`default_nettype none
module loch_dhcp_model (
  input wire logic clk_i,
  input wire logic [63:0] offer_i,
  output logic [31:0] dyn_gateway_o,
  output logic [31:0] dyn_nserver_o
);
  // lease service handing out gateway and name server
  always_ff @(posedge clk_i) begin
    dyn_gateway_o <= offer_i[63:32];
    dyn_nserver_o <= offer_i[31:0];
  end
endmodule // loch_dhcp_model
`default_nettype wire

/* File: test/tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "loch_params.svh"
module tb;
  import loch_pkg::*;
  logic clk_i, arst_n_i, s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i, s_axi_wready_o;
  logic s_axi_bvalid_o, s_axi_bready_i, s_axi_arvalid_i, s_axi_arready_o;
  logic s_axi_rvalid_o, s_axi_rready_i, output_en_o, ready_o;
  logic [7:0] s_axi_awaddr_i, s_axi_araddr_i;
  logic [3:0] s_axi_wstrb_i;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
  logic [31:0] s_axi_wdata_i, s_axi_rdata_o, dyn_gateway_i, dyn_nserver_i, gateway_o, nserver_o;
  logic [31:0] seed, gw, ns, d;
  logic [63:0] offer;
  loch_cfg_t net_cfg_o;
  int bad_count, checks, i;
  loch_handler i_loch_handler (.*);
  loch_dhcp_model i_loch_dhcp_model (.clk_i(clk_i), .offer_i(offer),
    .dyn_gateway_o(dyn_gateway_i), .dyn_nserver_o(dyn_nserver_i));
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    return v ^ (v << 5);
  endfunction
  function automatic logic [31:0] pick(input logic dy, input logic [31:0] st, input logic [31:0] lr);
    return dy ? lr : st;
  endfunction
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] s);
    checks++;
    if (s !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic test_done;
    if (bad_count == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic tmo(input int n);
    cmp("wait", 32'h0, 32'(n >= 40));
    if (n >= 40) test_done();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] e = 2'h0);
    int n;
    @(posedge clk_i);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= v;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
      if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
      if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
    end while (!s_axi_bvalid_o && n < 40);
    s_axi_bready_i <= 1'b0;
    tmo(n);
    cmp("bresp", {30'h0, e}, {30'h0, s_axi_bresp_o});
  endtask
  task automatic rd(input logic [7:0] a, input logic [1:0] e = 2'h0);
    int n;
    @(posedge clk_i);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
      if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
    end while (!s_axi_rvalid_o && n < 40);
    s_axi_rready_i <= 1'b0;
    d = s_axi_rdata_o;
    tmo(n);
    cmp("rresp", {30'h0, e}, {30'h0, s_axi_rresp_o});
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    rd(a);
    cmp("rdata", e, d & m);
  endtask
  task automatic cm(input logic [31:0] v, input logic [31:0] e);
    wr(`LOCH_OFS_CMD, v);
    @(posedge clk_i);
    cmp("output_en", e, {31'h0, output_en_o});
  endtask
  task automatic rst;
    int n;
    repeat (4) @(posedge clk_i);
    arst_n_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    cmp("ready", 32'h0, {31'h0, ready_o});
    arst_n_i <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (!ready_o && n < 40);
    tmo(n);
    cmp("ready_cycles", 32'h4, 32'(n));
    repeat (2) @(posedge clk_i);
  endtask
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  initial begin
    {arst_n_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} = 4'h0;
    {s_axi_arvalid_i, s_axi_rready_i, s_axi_awaddr_i, s_axi_araddr_i} = 18'h00000;
    s_axi_wdata_i = 32'h00000000;
    s_axi_wstrb_i = 4'hF;
    seed = 32'h00012AD4;
    offer = {seed, ~seed};
    bad_count = 0;
    checks = 0;
    i_loch_handler.u_nv.cell_reg[0] = 32'h00000000;
    i_loch_handler.u_nv.cell_reg[1] = 32'h00000000;
    rst();
    for (i = 0; i < 8; i++) begin
      seed = xs(seed);
      offer <= {seed, xs(seed)};
      wr(`LOCH_OFS_CTRL, 32'(i & 3));
      rc(`LOCH_OFS_CTRL, 32'h7, 32'(i & 3));
      seed = xs(xs(seed));
      wr(`LOCH_OFS_GATEWAY, seed);
      if (!i[0]) gw = seed;
      seed = xs(seed);
      wr(`LOCH_OFS_NSERVER, seed);
      if (!i[0]) ns = seed;
      rc(`LOCH_OFS_GATEWAY, 32'hFFFFFFFF, pick(i[0], gw, offer[63:32]));
      rc(`LOCH_OFS_NSERVER, 32'hFFFFFFFF, pick(i[0] | i[1], ns, offer[31:0]));
      cmp("gateway", pick(i[0], gw, offer[63:32]), gateway_o);
      cmp("nserver", pick(i[0] | i[1], ns, offer[31:0]), nserver_o);
    end
    wr(`LOCH_OFS_CTRL, 32'h0);
    cm(32'h1, 32'h1);
    rc(`LOCH_OFS_STATUS, 32'h1, 32'h1);
    cm(32'h2, 32'h0);
    cm(32'h3, 32'h1);
    rst();
    cmp("output_en", 32'h0, {31'h0, output_en_o});
    rc(`LOCH_OFS_STATUS, 32'hA, 32'h0);
    cm(32'h1, 32'h1);
    wr(`LOCH_OFS_CTRL, 32'h4);
    rc(`LOCH_OFS_STATUS, 32'h8, 32'h8);
    cm(32'h2, 32'h0);
    rst();
    cmp("output_en", 32'h0, {31'h0, output_en_o});
    cm(32'h1, 32'h1);
    rst();
    cmp("output_en", 32'h1, {31'h0, output_en_o});
    rc(`LOCH_OFS_CTRL, 32'h4, 32'h4);
    rc(`LOCH_OFS_STATUS, 32'h2, 32'h2);
    cm(32'h2, 32'h1);
    cm(32'h5, 32'h0);
    cm(32'h1, 32'h1);
    cm(32'h2, 32'h0);
    rc(`LOCH_OFS_CMD, 32'hFFFFFFFF, 32'h0);
    wr(8'h20, 32'h1, `LOCH_RESP_SLVERR);
    rd(8'h3C, `LOCH_RESP_SLVERR);
    test_done();
  end
endmodule // tb
`default_nettype wire
